/* common/dpr_pkg.sv */
package dpr_pkg;

   // ------------------------------------------------------------------
   // register indices (word addresses on the register port)
   // ------------------------------------------------------------------
   localparam logic [15:0] DPR_OFS_MODE    = 16'h0001;
   localparam logic [15:0] DPR_OFS_STAT_LO = 16'h0002;
   localparam logic [15:0] DPR_OFS_STAT_HI = 16'h0003;
   localparam logic [15:0] DPR_OFS_ADDR    = 16'h0004;
   localparam logic [15:0] DPR_OFS_RATE    = 16'h0005;

   // ------------------------------------------------------------------
   // mode codes and reset values
   // ------------------------------------------------------------------
   localparam logic [15:0] DPR_MODE_RUN0    = 16'h0000;
   localparam logic [15:0] DPR_MODE_RUN1    = 16'h0001;
   localparam logic [15:0] DPR_MODE_FACTORY = 16'h0002;
   localparam logic [15:0] DPR_MODE_RESET   = 16'h0003;
   localparam logic [15:0] DPR_RST_MODE     = 16'h0000;
   localparam logic [7:0]  DPR_RST_ADDR     = 8'h01;
   localparam logic [7:0]  DPR_ADDR_MIN     = 8'h01;
   localparam logic [7:0]  DPR_ADDR_MAX     = 8'hF7;
   localparam logic [2:0]  DPR_RST_RATE     = 3'h0;
   localparam logic [2:0]  DPR_RATE_AUTO    = 3'h0;
   localparam logic [2:0]  DPR_RATE_MIN     = 3'h1;
   localparam logic [2:0]  DPR_RATE_MAX     = 3'h7;

   // ------------------------------------------------------------------
   // status word bit positions
   // ------------------------------------------------------------------
   localparam int DPR_ST_FB_RUN     = 0;
   localparam int DPR_ST_SSC_RUN    = 1;
   localparam int DPR_ST_SSC_MAPERR = 2;
   localparam int DPR_ST_SDP_MAPERR = 3;
   localparam int DPR_ST_FB_MAPERR  = 4;
   localparam int DPR_ST_SSC_CFGERR = 5;
   localparam int DPR_ST_SDP_CFGERR = 6;
   localparam int DPR_ST_FB_CFGERR  = 7;
   localparam int DPR_ST_EXT_MAPERR = 14;
   localparam int DPR_ST_SCR_RUN    = 15;
   localparam int DPR_ST_SCR_ERR    = 16;

   // ------------------------------------------------------------------
   // timing: module reset pulse length
   // ------------------------------------------------------------------
   localparam int DPR_CLK_HZ        = 40_000_000;
   localparam int DPR_RST_PULSE_NS  = 1000;
   localparam int DPR_RST_PULSE_CYC =
      (DPR_RST_PULSE_NS * (DPR_CLK_HZ / 1_000_000) + 999) / 1000;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dpr_req_type;

   typedef struct packed {
      logic fb_run;
      logic ssc_run;
      logic ssc_map_err;
      logic sdp_map_err;
      logic fb_map_err;
      logic ssc_cfg_err;
      logic sdp_cfg_err;
      logic fb_cfg_err;
      logic ext_map_err;
      logic scr_run;
      logic scr_err;
   } dpr_stat_type;

   typedef enum logic [1:0] {
      DPR_IDLE    = 2'b00,
      DPR_RESTORE = 2'b01,
      DPR_PULSE   = 2'b10
   } dpr_ctl_type;

endpackage : dpr_pkg

/* design/dpr_status_word.sv */
`timescale 1ns/1ps
module dpr_status_word
   import dpr_pkg::*;
(
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // control
   input  wire logic         init_in,
   input  wire dpr_stat_type stat_in,
   // status word
   output logic [31:0]       word_out
);

   // ------------------------------------------------------------------
   // ssc master config error latch
   // ------------------------------------------------------------------
   // only sampled while init runs; later errors are ignored
   logic ssc_cfg_err;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ssc_cfg_err <= 1'b0;
      end else if (init_in) begin
         ssc_cfg_err <= stat_in.ssc_cfg_err;
      end
   end

   // ------------------------------------------------------------------
   // word register, reserved bits forced low
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         word_out <= 32'h0000_0000;
      end else begin
         word_out                    <= 32'h0000_0000;
         word_out[DPR_ST_FB_RUN]     <= stat_in.fb_run;
         word_out[DPR_ST_SSC_RUN]    <= stat_in.ssc_run;
         word_out[DPR_ST_SSC_MAPERR] <= stat_in.ssc_map_err;
         word_out[DPR_ST_SDP_MAPERR] <= stat_in.sdp_map_err;
         word_out[DPR_ST_FB_MAPERR]  <= stat_in.fb_map_err;
         word_out[DPR_ST_EXT_MAPERR] <= stat_in.ext_map_err;
         word_out[DPR_ST_SSC_CFGERR] <= ssc_cfg_err;
         word_out[DPR_ST_SDP_CFGERR] <= stat_in.sdp_cfg_err;
         word_out[DPR_ST_FB_CFGERR]  <= stat_in.fb_cfg_err;
         word_out[DPR_ST_SCR_RUN]    <= stat_in.scr_run;
         word_out[DPR_ST_SCR_ERR]    <= stat_in.scr_err;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   ssc_err_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !init_in ##1 !init_in |-> $stable(ssc_cfg_err))
      else $error("ssc config error changed outside init");

   reserved_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      word_out[13:8] == 6'h00 && word_out[31:17] == 15'h0000)
      else $error("reserved status bits not zero");

   fb_run_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rst_n_in |=> word_out[DPR_ST_FB_RUN] == $past(stat_in.fb_run))
      else $error("fieldbus run bit wrong");

endmodule : dpr_status_word

/* design/dpr_rate_hunt.sv */
`timescale 1ns/1ps
module dpr_rate_hunt
   import dpr_pkg::*;
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // configuration latched at module init
   input  wire logic [2:0] cfg_rate_in,
   // frame events from the receiver
   input  wire logic       frame_ok_in,
   input  wire logic       frame_bad_in,
   // result
   output logic [2:0]      rate_out,
   output logic            locked_out
);

   // ------------------------------------------------------------------
   // candidate stepping, 1 (2400) up to 7 (115200), wrap around
   // ------------------------------------------------------------------
   // a fixed rate is locked from the start; auto starts at the lowest
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rate_out   <= DPR_RATE_MIN;
         locked_out <= 1'b0;
      end else if (cfg_rate_in != DPR_RATE_AUTO) begin
         rate_out   <= cfg_rate_in;
         locked_out <= 1'b1;
      end else if (!locked_out) begin
         if (frame_ok_in) begin
            locked_out <= 1'b1;
         end else if (frame_bad_in) begin
            rate_out <= (rate_out == DPR_RATE_MAX) ? DPR_RATE_MIN
                                                   : rate_out + 3'h1;
         end
      end
   end

   rate_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rst_n_in && cfg_rate_in == DPR_RATE_AUTO && !locked_out && !frame_ok_in && frame_bad_in
      && rate_out != DPR_RATE_MAX |=> rate_out == $past(rate_out) + 3'h1)
      else $error("auto rate did not step");

endmodule : dpr_rate_hunt

/* design/dpr_param_regs.sv */
`timescale 1ns/1ps
module dpr_param_regs
   import dpr_pkg::*;
(
   // clock and reset
   input  wire logic         clk_sys_in,
   input  wire logic         rst_n_in,
   // register port from the serial protocol engine
   input  wire dpr_req_type  req_in,
   output logic [15:0]       rdata_out,
   output logic              ack_out,
   // frame events and reply gate
   input  wire logic [7:0]   frame_addr_in,
   input  wire logic         frame_ok_in,
   input  wire logic         frame_bad_in,
   input  wire logic         reply_req_in,
   output logic              reply_en_out,
   // live status sources
   input  wire dpr_stat_type stat_in,
   // persistent storage
   input  wire logic         nv_valid_in,
   input  wire logic [7:0]   nv_addr_in,
   input  wire logic [2:0]   nv_rate_in,
   output logic              nv_save_out,
   output logic [7:0]        nv_addr_out,
   output logic [2:0]        nv_rate_out,
   // module control
   output logic              cyclic_en_out,
   output logic              module_rst_out,
   output logic              init_out,
   output logic [7:0]        active_addr_out,
   output logic [2:0]        active_rate_out,
   output logic              rate_locked_out
);

   // ------------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------------
   logic rst_meta;
   logic rst_sync_n;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [15:0] mode;
   logic [7:0]  addr_cfg;
   logic [2:0]  rate_cfg;
   logic [7:0]  pulse_cnt;
   logic        nv_loaded;
   logic        save_req;
   logic [31:0] status_word;
   logic        internal_rst_n;
   logic        wr_mode;
   logic        wr_addr;
   logic        wr_rate;
   dpr_ctl_type ctl;
   dpr_ctl_type next_ctl;

   // commanded reset also clears the run-time logic
   // module_rst_out comes straight from a flop, so this derived reset cannot glitch
   assign internal_rst_n = rst_sync_n & ~module_rst_out;

   assign wr_mode = req_in.wr && req_in.addr == DPR_OFS_MODE;
   assign wr_addr = req_in.wr && req_in.addr == DPR_OFS_ADDR;
   assign wr_rate = req_in.wr && req_in.addr == DPR_OFS_RATE;

   // ------------------------------------------------------------------
   // mode register
   // ------------------------------------------------------------------
   // values above 3 are out of range and dropped
   always_ff @(posedge clk_sys_in or negedge internal_rst_n) begin
      if (!internal_rst_n) begin
         mode <= DPR_RST_MODE;
      end else if (wr_mode && req_in.wdata <= DPR_MODE_RESET) begin
         mode <= req_in.wdata;
      end
   end

   // cyclic exchange only in the two run codes
   assign cyclic_en_out = (mode == DPR_MODE_RUN0 || mode == DPR_MODE_RUN1)
                          && !module_rst_out;

   // ------------------------------------------------------------------
   // restore / reset sequencer
   // ------------------------------------------------------------------
   always_comb begin
      next_ctl = ctl;
      unique case (ctl)
         DPR_IDLE: begin
            if (wr_mode && req_in.wdata == DPR_MODE_FACTORY) begin
               next_ctl = DPR_RESTORE;
            end else if (wr_mode && req_in.wdata == DPR_MODE_RESET) begin
               next_ctl = DPR_PULSE;
            end
         end
         DPR_RESTORE: begin
            next_ctl = DPR_PULSE;
         end
         DPR_PULSE: begin
            if (pulse_cnt == 8'h01) begin
               next_ctl = DPR_IDLE;
            end
         end
         default: begin
            next_ctl = DPR_IDLE;
         end
      endcase
   end

   // sequencer survives the pulse it produces
   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ctl <= DPR_IDLE;
      end else begin
         ctl <= next_ctl;
      end
   end

   // pulse length counter
   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pulse_cnt <= 8'h00;
      end else if (ctl != DPR_PULSE && next_ctl == DPR_PULSE) begin
         pulse_cnt <= 8'(DPR_RST_PULSE_CYC);
      end else if (pulse_cnt != 8'h00) begin
         pulse_cnt <= pulse_cnt - 8'h01;
      end
   end

   // registered reset output
   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         module_rst_out <= 1'b0;
      end else begin
         module_rst_out <= (next_ctl == DPR_PULSE);
      end
   end

   // ------------------------------------------------------------------
   // persistent configuration: address and bitrate
   // ------------------------------------------------------------------
   // a bad stored image falls back to defaults
   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         addr_cfg  <= DPR_RST_ADDR;
         rate_cfg  <= DPR_RST_RATE;
         nv_loaded <= 1'b0;
      end else if (ctl == DPR_RESTORE) begin
         addr_cfg <= DPR_RST_ADDR;
         rate_cfg <= DPR_RST_RATE;
      end else if (!nv_loaded) begin
         nv_loaded <= 1'b1;
         if (nv_valid_in && nv_addr_in >= DPR_ADDR_MIN && nv_addr_in <= DPR_ADDR_MAX) begin
            addr_cfg <= nv_addr_in;
         end
         if (nv_valid_in && nv_rate_in <= DPR_RATE_MAX) begin
            rate_cfg <= nv_rate_in;
         end
      end else begin
         if (wr_addr && req_in.wdata[7:0] >= DPR_ADDR_MIN
             && req_in.wdata[7:0] <= DPR_ADDR_MAX && req_in.wdata[15:8] == 8'h00) begin
            addr_cfg <= req_in.wdata[7:0];
         end
         if (wr_rate && req_in.wdata <= 16'(DPR_RATE_MAX)) begin
            rate_cfg <= req_in.wdata[2:0];
         end
      end
   end

   // save strobe to storage on any address or rate write, accepted or not, and on restore; the strobe waits one
   // cycle so that it meets the registered copy of the new value
   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         save_req    <= 1'b0;
         nv_save_out <= 1'b0;
         nv_addr_out <= DPR_RST_ADDR;
         nv_rate_out <= DPR_RST_RATE;
      end else begin
         save_req    <= nv_loaded && (wr_addr || wr_rate || ctl == DPR_RESTORE);
         nv_save_out <= save_req;
         nv_addr_out <= addr_cfg;
         nv_rate_out <= rate_cfg;
      end
   end

   // ------------------------------------------------------------------
   // active link settings, loaded only at module init
   // ------------------------------------------------------------------
   assign init_out = nv_loaded && (ctl == DPR_IDLE) && !module_rst_out
                     && (active_addr_out == 8'h00);
   always_ff @(posedge clk_sys_in or negedge internal_rst_n) begin
      if (!internal_rst_n) begin
         active_addr_out <= 8'h00;
      end else if (init_out) begin
         active_addr_out <= addr_cfg;
      end
   end

   // bitrate setting follows the address: loaded only at init
   logic [2:0] active_rate_cfg;
   always_ff @(posedge clk_sys_in or negedge internal_rst_n) begin
      if (!internal_rst_n) begin
         active_rate_cfg <= DPR_RST_RATE;
      end else if (init_out) begin
         active_rate_cfg <= rate_cfg;
      end
   end

   // frame events are ignored in the init cycle, while the setting loads
   dpr_rate_hunt u_rate_hunt (
      .clk_in       (clk_sys_in),
      .rst_n_in     (internal_rst_n),
      .cfg_rate_in  (active_rate_cfg),
      .frame_ok_in  (frame_ok_in && !init_out),
      .frame_bad_in (frame_bad_in && !init_out),
      .rate_out     (active_rate_out),
      .locked_out   (rate_locked_out)
   );

   // replies only once the rate is found and addressed to us
   assign reply_en_out = reply_req_in && rate_locked_out
                         && frame_addr_in == active_addr_out;

   // ------------------------------------------------------------------
   // status word
   // ------------------------------------------------------------------
   dpr_status_word u_status (
      .clk_in   (clk_sys_in),
      .rst_n_in (internal_rst_n),
      .init_in  (init_out),
      .stat_in  (stat_in),
      .word_out (status_word)
   );

   // ------------------------------------------------------------------
   // read path and acknowledge
   // ------------------------------------------------------------------
   // status registers ignore writes; unmapped reads return zero
   always_ff @(posedge clk_sys_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata_out <= 16'h0000;
         ack_out   <= 1'b0;
      end else begin
         ack_out <= req_in.rd || req_in.wr;
         if (req_in.rd) begin
            unique case (req_in.addr)
               DPR_OFS_MODE:    rdata_out <= mode;
               DPR_OFS_STAT_LO: rdata_out <= status_word[15:0];
               DPR_OFS_STAT_HI: rdata_out <= status_word[31:16];
               DPR_OFS_ADDR:    rdata_out <= {8'h00, addr_cfg};
               DPR_OFS_RATE:    rdata_out <= {13'h0000, rate_cfg};
               default:         rdata_out <= 16'h0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   factory_seq_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      ctl == DPR_IDLE && wr_mode && req_in.wdata == DPR_MODE_FACTORY
      |=> ##1 module_rst_out && addr_cfg == DPR_RST_ADDR)
      else $error("factory restore did not reset");

   reset_cmd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      ctl == DPR_IDLE && wr_mode && req_in.wdata == DPR_MODE_RESET |=> module_rst_out)
      else $error("reset code gave no module reset");

   cyclic_mode_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      cyclic_en_out |-> mode[15:1] == 15'h0000)
      else $error("cyclic enabled in wrong mode");

   addr_range_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      addr_cfg >= DPR_ADDR_MIN && addr_cfg <= DPR_ADDR_MAX)
      else $error("device address out of range");

   addr_latch_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      !init_out && !module_rst_out && next_ctl != DPR_PULSE && active_addr_out != 8'h00
      |=> $stable(active_addr_out))
      else $error("active address changed without reset");

   no_reply_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      !rate_locked_out |-> !reply_en_out)
      else $error("reply sent during rate detection");

   status_read_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      req_in.rd && req_in.addr == DPR_OFS_STAT_HI |=> rdata_out == $past(status_word[31:16]))
      else $error("status high word read wrong");

   status_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      req_in.rd && req_in.addr == DPR_OFS_STAT_LO |=> rdata_out == $past(status_word[15:0]))
      else $error("status low word read wrong");

   init_once_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      init_out |=> !init_out)
      else $error("init lasted more than one cycle");

   fixed_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      active_rate_cfg != DPR_RATE_AUTO && next_ctl != DPR_PULSE
      |=> rate_locked_out && active_rate_out == $past(active_rate_cfg))
      else $error("fixed bitrate not locked");

   rate_latch_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      !init_out && !module_rst_out && next_ctl != DPR_PULSE |=> $stable(active_rate_cfg))
      else $error("active bitrate changed without reset");

   restore_nv_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      ctl == DPR_RESTORE |=> ##1 nv_save_out && nv_addr_out == DPR_RST_ADDR
      && nv_rate_out == DPR_RST_RATE)
      else $error("factory values not saved");

   pulse_end_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_n)
      $fell(module_rst_out) |-> init_out)
      else $error("no init after module reset");

endmodule : dpr_param_regs

/* verification/dpr_master_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// serial master: request frames toward the module
// ----------------------------------------
module dpr_master_model (
   // clock
   input  wire logic clk_in,
   // frame events seen by the receiver
   output logic [7:0] frame_addr_out,
   output logic       frame_ok_out,
   output logic       frame_bad_out,
   output logic       reply_req_out
);
   // idle line: no events, no stale address byte
   initial begin
      frame_addr_out = 8'hFF;
      frame_ok_out   = 1'b0;
      frame_bad_out  = 1'b0;
      reply_req_out  = 1'b0;
   end
   // one frame; a broken tail models a frame sent at the wrong bitrate
   task automatic send(input logic [7:0] dev, input logic good);
      @(negedge clk_in);
      frame_addr_out = dev;
      frame_ok_out   = good;
      frame_bad_out  = !good;
      reply_req_out  = 1'b1;
      @(negedge clk_in);
      frame_ok_out   = 1'b0;
      frame_bad_out  = 1'b0;
   endtask : send
   // release: inverse byte so a missing compare cannot match by luck
   task automatic release_line();
      reply_req_out  = 1'b0;
      frame_addr_out = ~frame_addr_out;
   endtask : release_line
endmodule : dpr_master_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import dpr_pkg::*;
;
   logic         clk_sys_in = 1'b0;
   logic         rst_n_in   = 1'b0;
   dpr_req_type  req        = '0;
   dpr_stat_type stat       = '0;
   logic [15:0]  rdata_out, rd;
   logic [7:0]   fa, nv_addr_out, active_addr_out, a;
   logic [2:0]   nv_rate_out, active_rate_out;
   logic         ack_out, fok, fbad, rreq, reply_en_out, nv_save_out, cyclic_en_out;
   logic         module_rst_out, init_out, rate_locked_out, seen;
   int           fails = 0, check_count = 0, cyc = 0, k;

   always #12.5 clk_sys_in = ~clk_sys_in;

   dpr_param_regs dut (.clk_sys_in, .rst_n_in, .req_in(req), .rdata_out, .ack_out,
      .frame_addr_in(fa), .frame_ok_in(fok), .frame_bad_in(fbad), .reply_req_in(rreq),
      .reply_en_out, .stat_in(stat), .nv_valid_in(1'b1), .nv_addr_in(8'h22),
      .nv_rate_in(DPR_RATE_AUTO), .nv_save_out, .nv_addr_out, .nv_rate_out, .cyclic_en_out,
      .module_rst_out, .init_out, .active_addr_out, .active_rate_out, .rate_locked_out);
   dpr_master_model mst (.clk_in(clk_sys_in), .frame_addr_out(fa), .frame_ok_out(fok),
      .frame_bad_out(fbad), .reply_req_out(rreq));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   // one register cycle; ack and data are taken one cycle after the request
   task automatic bus(input logic wr, input logic [15:0] ad, input logic [15:0] wd);
      @(negedge clk_sys_in);
      req = '{wr: wr, rd: !wr, addr: ad, wdata: wd};
      @(negedge clk_sys_in);
      req = '0;
      check("ack", 32'h1, ack_out);
      rd = rdata_out;
   endtask : bus
   task automatic rdreg(input logic [15:0] ad, input logic [15:0] exp, input string what);
      bus(1'b0, ad, 16'h0000);
      check(what, exp, rd);
   endtask : rdreg
   // status word as the bits should read; reserved bits fixed at zero
   function automatic logic [31:0] exp_stat(input dpr_stat_type s, input logic b5);
      exp_stat = {15'h0, s.scr_err, s.scr_run, s.ext_map_err, 6'h00, s.fb_cfg_err,
         s.sdp_cfg_err, b5, s.fb_map_err, s.sdp_map_err, s.ssc_map_err, s.ssc_run, s.fb_run};
   endfunction : exp_stat
   // waits out a module reset; pulse length only checked when it was caught at its start
   task automatic wait_init(input logic chk_len);
      k = 0;
      while (module_rst_out !== 1'b1 && k < 10) begin
         @(negedge clk_sys_in);
         k++;
      end
      k = 0;
      while (module_rst_out === 1'b1 && k < 200) begin
         @(negedge clk_sys_in);
         k++;
      end
      if (chk_len) begin
         check("rst_len", DPR_RST_PULSE_CYC, k);
      end
      repeat (4) @(negedge clk_sys_in);
   endtask : wait_init
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h0451));
      repeat (10) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      repeat (5) @(negedge clk_sys_in);
      rdreg(DPR_OFS_MODE, DPR_RST_MODE, "mode");
      rdreg(DPR_OFS_ADDR, 16'h0022, "addr");
      rdreg(16'h0040, 16'h0000, "unmapped");
      check("cyclic", 32'h1, cyclic_en_out);
      $display("test reset_values done");
      // status follows live sources; bit 5 stays as sampled at init
      for (int i = 0; i < 20; i++) begin
         stat = dpr_stat_type'(11'($urandom));
         bus(1'b1, (i[0] ? DPR_OFS_STAT_HI : DPR_OFS_STAT_LO), 16'hFFFF);
         rdreg(DPR_OFS_STAT_LO, 16'(exp_stat(stat, 1'b0)), "stat_lo");
         rdreg(DPR_OFS_STAT_HI, 16'(exp_stat(stat, 1'b0) >> 16), "stat_hi");
      end
      $display("test status done");
      // address range edges, pending settings held until reset
      a = 8'(1 + $urandom_range(246));
      bus(1'b1, DPR_OFS_ADDR, {8'h00, a});
      bus(1'b1, DPR_OFS_ADDR, 16'h00F8);
      bus(1'b1, DPR_OFS_ADDR, 16'h0000);
      rdreg(DPR_OFS_ADDR, {8'h00, a}, "addr_wr");
      bus(1'b1, DPR_OFS_RATE, 16'h0004);
      bus(1'b1, DPR_OFS_MODE, DPR_MODE_RUN1);
      check("act_addr", 32'h22, active_addr_out);
      check("cyclic1", 32'h1, cyclic_en_out);
      stat.ssc_cfg_err = 1'b1;
      bus(1'b1, DPR_OFS_MODE, DPR_MODE_RESET);
      wait_init(1'b1);
      check("act_addr2", a, active_addr_out);
      check("act_rate", 32'h4, active_rate_out);
      rdreg(DPR_OFS_STAT_LO, 16'(exp_stat(stat, 1'b1)), "stat_b5");
      mst.send(a, 1'b1);
      check("reply_fix", 32'h1, reply_en_out);
      mst.release_line();
      $display("test fixed_rate done");
      // automatic detection: silent and stepping until a good frame
      bus(1'b1, DPR_OFS_RATE, DPR_RATE_AUTO);
      bus(1'b1, DPR_OFS_MODE, DPR_MODE_RESET);
      wait_init(1'b0);
      k = 3 + $urandom_range(30);
      for (int i = 0; i < k; i++) begin
         mst.send(a, 1'b0);
         check("reply_hunt", 32'h0, reply_en_out);
         mst.release_line();
      end
      check("hunt_rate", (k % 7) + 1, active_rate_out);
      mst.send(a, 1'b1);
      check("locked", 32'h1, rate_locked_out);
      check("reply_lock", 32'h1, reply_en_out);
      mst.release_line();
      $display("test auto_rate done");
      // factory restore resets on its own
      bus(1'b1, DPR_OFS_MODE, DPR_MODE_FACTORY);
      seen = 1'b0;
      repeat (6) begin
         @(negedge clk_sys_in);
         seen = seen | (nv_save_out === 1'b1 && nv_addr_out === DPR_RST_ADDR
                        && nv_rate_out === DPR_RST_RATE);
      end
      check("nv_save", 32'h1, seen);
      wait_init(1'b0);
      rdreg(DPR_OFS_ADDR, {8'h00, DPR_RST_ADDR}, "addr_fac");
      rdreg(DPR_OFS_RATE, {13'h0, DPR_RST_RATE}, "rate_fac");
      check("act_fac", DPR_RST_ADDR, active_addr_out);
      $display("test factory done");
      tally_and_finish();
   end
endmodule : tb_top
